// >>> design/supervisor_pkg.sv
// Purpose: Shared constants for the autowake and watchdog supervisor.
// Assumes: 10 MHz system clock, 32768 Hz time base derived by a divider.
// Notes:   Offsets are byte addresses on the 8-bit register port.
package supervisor_pkg;

   // --------------------------------------------------------------
   // Clocking and time base
   // --------------------------------------------------------------
   localparam int CLK_HZ         = 10_000_000;
   localparam int BASE_HZ        = 32_768;
   localparam int TICK_DIV       = CLK_HZ / BASE_HZ;
   localparam int STEP_SHORT_MS  = 2_500;
   localparam int STEP_LONG_MS   = 60_000;
   localparam int DOG_TIMEOUT_MS = 1_500;
   localparam int NEAR_US        = 1_000;
   localparam int STEP_SHORT_TICKS  = STEP_SHORT_MS * BASE_HZ / 1_000;
   localparam int STEP_LONG_TICKS   = STEP_LONG_MS * BASE_HZ / 1_000;
   localparam int DOG_TIMEOUT_TICKS = DOG_TIMEOUT_MS * BASE_HZ / 1_000;
   localparam int NEAR_TICKS        = NEAR_US * BASE_HZ / 1_000_000;

   // --------------------------------------------------------------
   // Register offsets
   // --------------------------------------------------------------
   localparam logic [15:0] OFS_DOG_RESTART = 16'h00F8;
   localparam logic [15:0] OFS_DOG_EXPIRED = 16'h2002;
   localparam logic [15:0] OFS_WAKE_CTRL   = 16'h20A9;
   localparam logic [15:0] OFS_DOG_NEAR    = 16'h20B1;
   localparam logic [15:0] OFS_IRQ_STATUS  = 16'h20C0;
   localparam logic [15:0] OFS_IRQ_MASK    = 16'h20C1;

   // --------------------------------------------------------------
   // Field positions and reset values
   // --------------------------------------------------------------
   localparam int PERIOD_MSB   = 2;
   localparam int STEP_SEL_BIT = 3;
   localparam int SLEEP_BIT    = 6;
   localparam int ARM_BIT      = 7;
   localparam int EXPIRED_BIT  = 2;
   localparam int NEAR_BIT     = 0;
   localparam int IRQ_WAKE     = 0;
   localparam int IRQ_NEAR     = 1;
   localparam int IRQ_EXPIRED  = 2;
   localparam logic [2:0] PERIOD_RST   = 3'h1;
   localparam logic       STEP_SEL_RST = 1'h0;
   localparam logic [7:0] RESTART_KEY  = 8'hFF;
   localparam logic [2:0] IRQ_MASK_RST = 3'h0;

   // --------------------------------------------------------------
   // Power modes and autowake timer states
   // --------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_FULL    = 2'h0,
      MODE_LOW     = 2'h1,
      MODE_SLEEP   = 2'h2,
      MODE_DISPLAY = 2'h3
   } power_mode_t;

   typedef enum logic [1:0] {
      T_IDLE  = 2'h0,
      T_ARMED = 2'h1,
      T_RUN   = 2'h3,
      T_FIRE  = 2'h2
   } timer_state_t;

endpackage

// >>> design/autowake_and_watchdog_supervisor.sv
// Purpose: Autowake timer, watchdog status flags and restart control.
// Assumes: Mode input and register port are on ref_clk_i; the button,
//          system power and reset pins are asynchronous.
// Notes:   All timers advance on the 32768 Hz tick enable.
`timescale 1ns/100ps

// --------------------------------------------------------------
// Pin synchroniser with agreement filter
// --------------------------------------------------------------
module pin_sync (
   input  wire logic ref_clk_i,
   input  wire logic rst_b_i,
   input  wire logic pin_i,
   output logic      level_o,
   output logic      rise_o
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   logic nxt_level;

   // Level moves only once stages two and three agree
   assign nxt_level = (s2_ff == s3_ff) ? s3_ff : level_o;

   // Three-stage chain plus filtered level and rising pulse
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s1_ff   <= 1'h0;
         s2_ff   <= 1'h0;
         s3_ff   <= 1'h0;
         level_o <= 1'h0;
         rise_o  <= 1'h0;
      end else begin
         s1_ff   <= pin_i;
         s2_ff   <= s1_ff;
         s3_ff   <= s2_ff;
         level_o <= nxt_level;
         rise_o  <= nxt_level & ~level_o;
      end
   end
endmodule

// Functional notes
// - Writing the arm bit arms the timer and loads period and step.
// - Full-power or low-supply mode holds an armed timer and disarms a running one.
// - Sleep time is period times step; period resets to one, max seven.
// - Step select one gives one-minute steps, zero gives 2.5 seconds.
// - Near flag sets 1 ms before overflow, clears on wake falling.
// - Restart register takes whole bytes; 0xFF restarts the watchdog.
// - Expired flag sets on overflow, persists, clears while reset pin high.
// - Sleep wakes on timer expiry, button, power return or reset pin high.
module autowake_and_watchdog_supervisor #(
   parameter logic [20:0] STEP_SHORT_TICKS =
      21'(supervisor_pkg::STEP_SHORT_TICKS),
   parameter logic [20:0] STEP_LONG_TICKS  =
      21'(supervisor_pkg::STEP_LONG_TICKS),
   parameter logic [15:0] DOG_TIMEOUT_TICKS =
      16'(supervisor_pkg::DOG_TIMEOUT_TICKS)
) (
   input  wire logic        ref_clk_i,
   input  wire logic        rst_b_i,
   input  wire logic [15:0] addr_i,
   input  wire logic [7:0]  wr_data_i,
   input  wire logic        wr_en_i,
   input  wire logic        rd_en_i,
   output logic      [7:0]  rd_data_o,
   input  wire logic [1:0]  mode_i,
   input  wire logic        button_i,
   input  wire logic        sys_power_i,
   input  wire logic        reset_pin_i,
   output logic             sleep_req_o,
   output logic             wake_o,
   output logic             dog_reset_o,
   output logic             irq_o
);
   localparam logic [8:0]  TICK_LAST = 9'(supervisor_pkg::TICK_DIV - 1);
   localparam logic [15:0] NEAR_TICKS = 16'(supervisor_pkg::NEAR_TICKS);

   logic [8:0]  div_ff;
   logic        tick_ff;
   logic [2:0]  wake_period_ff;
   logic        wake_step_select_ff;
   logic        run_long_ff;
   logic [20:0] step_cnt_ff;
   logic [2:0]  left_ff;
   logic [15:0] dog_cnt_ff;
   logic        dog_near_expiry_flag_ff;
   logic        dog_expired_flag_ff;
   logic [2:0]  irq_status_ff;
   logic [2:0]  irq_mask_ff;
   logic        wake_ff;
   logic        sleep_req_ff;
   logic        dog_reset_ff;
   logic        irq_ff;
   logic [7:0]  rd_data_ff;
   supervisor_pkg::timer_state_t state_ff;
   supervisor_pkg::timer_state_t nxt_state;

   logic btn_level, btn_rise, pwr_level, pwr_rise, pin_level, pin_rise;

   // --------------------------------------------------------------
   // Pin inputs
   // --------------------------------------------------------------
   pin_sync u_btn_sync (
      .ref_clk_i (ref_clk_i), .rst_b_i (rst_b_i), .pin_i (button_i),
      .level_o (btn_level), .rise_o (btn_rise));
   pin_sync u_pwr_sync (
      .ref_clk_i (ref_clk_i), .rst_b_i (rst_b_i), .pin_i (sys_power_i),
      .level_o (pwr_level), .rise_o (pwr_rise));
   pin_sync u_pin_sync (
      .ref_clk_i (ref_clk_i), .rst_b_i (rst_b_i), .pin_i (reset_pin_i),
      .level_o (pin_level), .rise_o (pin_rise));

   // --------------------------------------------------------------
   // Register decode
   // --------------------------------------------------------------
   wire wr_ctrl    = wr_en_i && (addr_i == supervisor_pkg::OFS_WAKE_CTRL);
   wire wr_restart = wr_en_i && (addr_i == supervisor_pkg::OFS_DOG_RESTART);
   wire wr_expired = wr_en_i && (addr_i == supervisor_pkg::OFS_DOG_EXPIRED);
   wire wr_near    = wr_en_i && (addr_i == supervisor_pkg::OFS_DOG_NEAR);
   wire wr_status  = wr_en_i && (addr_i == supervisor_pkg::OFS_IRQ_STATUS);
   wire wr_mask    = wr_en_i && (addr_i == supervisor_pkg::OFS_IRQ_MASK);
   wire arm_wr     = wr_ctrl && wr_data_i[supervisor_pkg::ARM_BIT];
   wire sleep_wr   = wr_ctrl && wr_data_i[supervisor_pkg::SLEEP_BIT];
   wire restart    = wr_restart &&
                     (wr_data_i == supervisor_pkg::RESTART_KEY);

   // Battery modes let the timer run; the others hold an armed timer and disarm a running one
   wire mode_sleep = (mode_i == supervisor_pkg::MODE_SLEEP);
   wire battery    = mode_sleep || (mode_i == supervisor_pkg::MODE_DISPLAY);

   // --------------------------------------------------------------
   // Time base divider
   // --------------------------------------------------------------
   wire div_end = (div_ff == TICK_LAST);

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         div_ff  <= 9'h000;
         tick_ff <= 1'h0;
      end else begin
         div_ff  <= div_end ? 9'h000 : div_ff + 9'h001;
         tick_ff <= div_end;
      end
   end

   // --------------------------------------------------------------
   // Autowake timer
   // --------------------------------------------------------------
   // Step length fixed at arm; later control writes leave it alone
   wire [20:0] step_len = run_long_ff ? STEP_LONG_TICKS
                                      : STEP_SHORT_TICKS;
   wire step_end = (step_cnt_ff == step_len - 21'h000001);
   wire expire   = tick_ff && ((left_ff == 3'h0) ||
                   ((left_ff == 3'h1) && step_end));

   // Timer sequence: idle, armed, running, firing
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         supervisor_pkg::T_IDLE: begin
            if (arm_wr) nxt_state = supervisor_pkg::T_ARMED;
         end
         supervisor_pkg::T_ARMED: begin
            if (!arm_wr && battery) nxt_state = supervisor_pkg::T_RUN;
         end
         supervisor_pkg::T_RUN: begin
            if (!battery) nxt_state = supervisor_pkg::T_IDLE;
            else if (arm_wr) nxt_state = supervisor_pkg::T_ARMED;
            else if (expire) nxt_state = supervisor_pkg::T_FIRE;
         end
         supervisor_pkg::T_FIRE: begin
            nxt_state = arm_wr ? supervisor_pkg::T_ARMED
                               : supervisor_pkg::T_IDLE;
         end
         default: nxt_state = supervisor_pkg::T_IDLE;
      endcase
   end

   // Settings, state and step counters
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wake_period_ff      <= supervisor_pkg::PERIOD_RST;
         wake_step_select_ff <= supervisor_pkg::STEP_SEL_RST;
         run_long_ff         <= supervisor_pkg::STEP_SEL_RST;
         state_ff            <= supervisor_pkg::T_IDLE;
         step_cnt_ff         <= 21'h000000;
         left_ff             <= 3'h0;
      end else begin
         state_ff <= nxt_state;
         if (wr_ctrl) begin
            wake_period_ff      <= wr_data_i[supervisor_pkg::PERIOD_MSB:0];
            wake_step_select_ff <= wr_data_i[supervisor_pkg::STEP_SEL_BIT];
         end
         if (arm_wr) begin
            step_cnt_ff <= 21'h000000;
            run_long_ff <= wr_data_i[supervisor_pkg::STEP_SEL_BIT];
            left_ff     <= wr_data_i[supervisor_pkg::PERIOD_MSB:0];
         end else if (state_ff == supervisor_pkg::T_RUN && tick_ff) begin
            step_cnt_ff <= step_end ? 21'h000000 : step_cnt_ff + 21'h000001;
            if (step_end && left_ff != 3'h0) left_ff <= left_ff - 3'h1;
         end
      end
   end

   // --------------------------------------------------------------
   // Wake and sleep control
   // --------------------------------------------------------------
   wire wake_ev  = (state_ff == supervisor_pkg::T_FIRE) ||
                   (mode_sleep && (btn_rise || pwr_rise || pin_rise));
   wire wake_fall = wake_ff && !wake_ev;

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wake_ff      <= 1'h0;
         sleep_req_ff <= 1'h0;
      end else begin
         wake_ff <= wake_ev;
         if (wake_ev || pwr_level) sleep_req_ff <= 1'h0;
         else if (sleep_wr) sleep_req_ff <= 1'h1;   // Ignored on mains
      end
   end

   // --------------------------------------------------------------
   // Watchdog counter and flags
   // --------------------------------------------------------------
   wire dog_ovf  = tick_ff && (dog_cnt_ff == DOG_TIMEOUT_TICKS - 16'h0001);
   wire near_set = tick_ff &&
                   (dog_cnt_ff == DOG_TIMEOUT_TICKS - NEAR_TICKS - 16'h0001);
   wire near_clr = wake_fall ||
                   (wr_near && !wr_data_i[supervisor_pkg::NEAR_BIT]);
   wire exp_clr  = pin_level ||
                   (wr_expired && !wr_data_i[supervisor_pkg::EXPIRED_BIT]);
   wire [2:0] events = {dog_ovf, near_set, wake_ev};
   wire [2:0] nxt_status = events |
                   (irq_status_ff & ~(wr_status ? wr_data_i[2:0] : 3'h0));

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         dog_cnt_ff              <= 16'h0000;
         dog_near_expiry_flag_ff <= 1'h0;
         dog_expired_flag_ff     <= 1'h0;
         dog_reset_ff            <= 1'h0;
      end else begin
         if (restart || dog_ovf) dog_cnt_ff <= 16'h0000;
         else if (tick_ff) dog_cnt_ff <= dog_cnt_ff + 16'h0001;
         dog_reset_ff <= dog_ovf;
         if (near_set) dog_near_expiry_flag_ff <= 1'h1;
         else if (near_clr) dog_near_expiry_flag_ff <= 1'h0;
         if (dog_ovf) dog_expired_flag_ff <= 1'h1;
         else if (exp_clr) dog_expired_flag_ff <= 1'h0;
      end
   end

   // --------------------------------------------------------------
   // Interrupt status and mask
   // --------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_status_ff <= 3'h0;
         irq_mask_ff   <= supervisor_pkg::IRQ_MASK_RST;
         irq_ff        <= 1'h0;
      end else begin
         irq_status_ff <= nxt_status;                  // Set beats clear
         if (wr_mask) irq_mask_ff <= wr_data_i[2:0];
         irq_ff <= |(nxt_status & (wr_mask ? wr_data_i[2:0] : irq_mask_ff));
      end
   end

   // --------------------------------------------------------------
   // Read path
   // --------------------------------------------------------------
   wire [7:0] rd_ctrl = {4'h0, wake_step_select_ff, wake_period_ff};
   wire [7:0] rd_mux =
      (addr_i == supervisor_pkg::OFS_WAKE_CTRL)   ? rd_ctrl :
      (addr_i == supervisor_pkg::OFS_DOG_EXPIRED) ?
         {5'h00, dog_expired_flag_ff, 2'h0} :
      (addr_i == supervisor_pkg::OFS_DOG_NEAR)    ?
         {7'h00, dog_near_expiry_flag_ff} :
      (addr_i == supervisor_pkg::OFS_IRQ_STATUS)  ? {5'h00, irq_status_ff} :
      (addr_i == supervisor_pkg::OFS_IRQ_MASK)    ? {5'h00, irq_mask_ff} :
      8'h00;

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) rd_data_ff <= 8'h00;
      else rd_data_ff <= rd_en_i ? rd_mux : 8'h00;
   end

   assign rd_data_o   = rd_data_ff;
   assign sleep_req_o = sleep_req_ff;
   assign wake_o      = wake_ff;
   assign dog_reset_o = dog_reset_ff;
   assign irq_o       = irq_ff;

   // --------------------------------------------------------------
   // Checks
   // --------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);

   a_arm_loads: assert property (
      arm_wr |=> state_ff == supervisor_pkg::T_ARMED &&
                 left_ff == $past(wr_data_i[2:0]) && step_cnt_ff == 21'h0)
      else $error("arm write did not load the timer");
   a_hold_full: assert property (
      (state_ff == supervisor_pkg::T_RUN && !battery)
      |=> state_ff == supervisor_pkg::T_IDLE)
      else $error("timer kept running outside battery modes");
   a_period_down: assert property (
      (state_ff == supervisor_pkg::T_RUN && battery && !arm_wr && tick_ff &&
       step_end && left_ff > 3'h1) |=> left_ff == $past(left_ff) - 3'h1)
      else $error("period count did not step down");
   a_step_length: assert property (
      state_ff == supervisor_pkg::T_RUN |-> step_cnt_ff < step_len)
      else $error("step counter passed the selected step");
   a_near_clear: assert property (
      (wake_fall && !near_set) |=> !dog_near_expiry_flag_ff)
      else $error("near flag survived wake falling edge");
   a_restart_key: assert property (
      restart |=> dog_cnt_ff == 16'h0 ##1 !dog_reset_ff)
      else $error("restart key did not clear the watchdog");
   a_expire_set: assert property (
      dog_ovf |=> dog_expired_flag_ff && dog_reset_o)
      else $error("overflow did not set expired flag");
   a_expire_pin: assert property (
      (pin_level && !dog_ovf) |=> !dog_expired_flag_ff)
      else $error("expired flag held while reset pin high");
   a_wake_sleep: assert property (
      (mode_sleep && btn_rise) |=> wake_o)
      else $error("button did not wake from sleep");
   a_fire_once: assert property (
      state_ff == supervisor_pkg::T_FIRE |=> wake_o && !$past(arm_wr)
      |-> state_ff == supervisor_pkg::T_IDLE ##1 !wake_o || battery)
      else $error("expiry did not disarm after one wake");
endmodule

// >>> test/autowake_and_watchdog_supervisor_test.sv
// Purpose: Self-checking bench for the autowake and watchdog supervisor.
// Assumes: Short tick counts (4, 8, 64) set through the parameters.
// Notes:   One tick is 305 clocks; time windows allow one tick of phase.
`timescale 1ns/100ps
module autowake_and_watchdog_supervisor_test;
   localparam int T = 305;
   logic        ref_clk_i;
   logic        rst_b_i;
   logic [15:0] addr_i;
   logic [7:0]  wr_data_i;
   logic        wr_en_i;
   logic        rd_en_i;
   logic [7:0]  rd_data_o;
   logic [1:0]  mode_i;
   logic        button_i;
   logic        sys_power_i;
   logic        reset_pin_i;
   logic        sleep_req_o;
   logic        wake_o;
   logic        dog_reset_o;
   logic        irq_o;
   int          n_fail;
   int          n_tests;
   int          cyc;
   int          n;
   int          m;

   autowake_and_watchdog_supervisor #(
      .STEP_SHORT_TICKS  (21'h4),
      .STEP_LONG_TICKS   (21'h8),
      .DOG_TIMEOUT_TICKS (16'h40)
   ) autowake_and_watchdog_supervisor_inst (
      .ref_clk_i   (ref_clk_i),
      .rst_b_i     (rst_b_i),
      .addr_i      (addr_i),
      .wr_data_i   (wr_data_i),
      .wr_en_i     (wr_en_i),
      .rd_en_i     (rd_en_i),
      .rd_data_o   (rd_data_o),
      .mode_i      (mode_i),
      .button_i    (button_i),
      .sys_power_i (sys_power_i),
      .reset_pin_i (reset_pin_i),
      .sleep_req_o (sleep_req_o),
      .wake_o      (wake_o),
      .dog_reset_o (dog_reset_o),
      .irq_o       (irq_o)
   );

   // ----------------------------------------------------------
   // Clock and hang guard
   // ----------------------------------------------------------
   initial begin
      ref_clk_i = 1'b0;
      forever #50 ref_clk_i = ~ref_clk_i;
   end

   // Cuts the run short if a wait never ends
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         n_fail++;
         complete_run();
      end
   end

   // ----------------------------------------------------------
   // Access and compare tasks
   // ----------------------------------------------------------
   task complete_run();
      $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Cycle count must fall inside lo..hi
   task win(input string nm, input int lo, input int hi, input int got);
      n_tests++;
      if (got < lo || got > hi) begin
         n_fail++;
         $display("CHECK FAILED %s expected %0d..%0d seen %0d",
                  nm, lo, hi, got);
      end
   endtask

   task wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      addr_i    <= a;
      wr_data_i <= d;
      wr_en_i   <= 1'b1;
      @(posedge ref_clk_i);
      wr_en_i   <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge ref_clk_i);
      addr_i  <= a;
      rd_en_i <= 1'b1;
      @(posedge ref_clk_i);
      rd_en_i <= 1'b0;
      #1;
      chk($sformatf("read %h", a), exp, rd_data_o);
   endtask

   function automatic logic out_sel(input int s);
      return (s == 0) ? wake_o : (s == 1) ? irq_o : dog_reset_o;
   endfunction

   // Counts cycles until the chosen output is high, at most lim
   task wait_out(input int s, input int lim, output int k);
      k = 0;
      while (k < lim && out_sel(s) !== 1'b1) begin
         @(posedge ref_clk_i);
         #1;
         k++;
      end
   endtask

   task set_mode(input logic [1:0] md);
      @(posedge ref_clk_i);
      mode_i <= md;
   endtask

   task set_pin(input int p, input logic v);
      @(posedge ref_clk_i);
      case (p)
         0: sys_power_i <= v;
         1: button_i    <= v;
         default: reset_pin_i <= v;
      endcase
   endtask

   // ----------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------
   initial begin
      {n_fail, n_tests, cyc} = '0;
      rst_b_i = 1'b0;
      {addr_i, wr_data_i, wr_en_i, rd_en_i, mode_i} = '0;
      {button_i, reset_pin_i} = 2'h0;
      sys_power_i = 1'b1;
      repeat (8) @(posedge ref_clk_i);
      rst_b_i <= 1'b1;
      // Reset values, unmapped place, field write and readback
      rd(16'h20A9, 8'h01);
      rd(16'h2002, 8'h00);
      rd(16'h20C1, 8'h00);
      rd(16'h1234, 8'h00);
      wr(16'h20A9, 8'h0F);
      rd(16'h20A9, 8'h0F);
      // Armed timer holds in low-supply mode, runs in display-only
      wr(16'h00F8, 8'hFF);
      wr(16'h20C1, 8'h01);
      set_mode(2'h1);
      wr(16'h20A9, 8'h81);
      wait_out(0, 6 * T, n);
      win("wake while held", 6 * T, 6 * T, n);
      set_mode(2'h3);
      wait_out(0, 6 * T, n);
      win("short wake time", 3 * T, 5 * T + 4, n);
      @(posedge ref_clk_i);
      #1;
      chk("wake pulse", 8'h00, {7'h0, wake_o});
      chk("irq on wake", 8'h01, {7'h0, irq_o});
      wr(16'h20C1, 8'h00);
      #1;
      chk("irq masked", 8'h00, {7'h0, irq_o});
      rd(16'h20C0, 8'h01);
      wr(16'h20C0, 8'h01);
      wr(16'h20C1, 8'h01);
      #1;
      chk("irq cleared", 8'h00, {7'h0, irq_o});
      wait_out(0, 8 * T, n);
      win("second wake", 8 * T, 8 * T, n);
      // Period two with one-minute steps
      wr(16'h00F8, 8'hFF);
      wr(16'h20A9, 8'h8A);
      wait_out(0, 18 * T, n);
      win("long wake time", 15 * T, 17 * T + 4, n);
      rd(16'h20A9, 8'h0A);
      // Running timer is disarmed by full-power mode
      wr(16'h00F8, 8'hFF);
      wr(16'h20A9, 8'h81);
      set_mode(2'h2);
      repeat (2 * T) @(posedge ref_clk_i);
      set_mode(2'h0);
      repeat (5) @(posedge ref_clk_i);
      set_mode(2'h2);
      wait_out(0, 8 * T, n);
      win("wake after disarm", 8 * T, 8 * T, n);
      // Near flag, wrong restart key, overflow
      wr(16'h20C0, 8'h07);
      wr(16'h20C1, 8'h02);
      wr(16'h00F8, 8'hFF);
      wait_out(1, 40 * T, n);
      win("near time", 31 * T, 33 * T + 4, n);
      wr(16'h00F8, 8'hFE);
      wait_out(2, 40 * T, m);
      win("overflow time", 63 * T, 65 * T + 8, n + m + 2);
      rd(16'h2002, 8'h04);
      rd(16'h20B1, 8'h01);
      rd(16'h20C0, 8'h06);
      wr(16'h00F8, 8'hFF);
      repeat (20) @(posedge ref_clk_i);
      rd(16'h2002, 8'h04);
      // Boot code clears both flags; a written one is ignored
      wr(16'h2002, 8'h04);
      rd(16'h2002, 8'h04);
      wr(16'h2002, 8'h00);
      rd(16'h2002, 8'h00);
      wr(16'h20B1, 8'h00);
      rd(16'h20B1, 8'h00);
      // Let the watchdog run out again so both flags are set for the pins
      wait_out(2, 70 * T, m);
      rd(16'h2002, 8'h04);
      rd(16'h20B1, 8'h01);
      // Sleep command, then wake on each pin
      set_pin(0, 1'b0);
      repeat (10) @(posedge ref_clk_i);
      wr(16'h20A9, 8'h41);
      #1;
      chk("sleep request", 8'h01, {7'h0, sleep_req_o});
      for (int p = 0; p < 3; p++) begin
         set_pin(p, 1'b1);
         wait_out(0, 20, n);
         win($sformatf("pin %0d wake", p), 1, 19, n);
         repeat (10) @(posedge ref_clk_i);
         if (p == 0) begin
            #1;
            chk("sleep released", 8'h00, {7'h0, sleep_req_o});
         end
         set_pin(p, 1'b0);
         repeat (10) @(posedge ref_clk_i);
      end
      rd(16'h2002, 8'h00);
      rd(16'h20B1, 8'h00);
      complete_run();
   end
endmodule
